// ---- bench/gid_monitor.sv ----
// checker for the pin input and direction block
// assumes checks pause while ce_in is low, since every flop is frozen then
`timescale 1ns/1ps
module gid_monitor
   import gid_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [BUS_DATA_W-1:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [PIN_COUNT-1:0] pin_drive_in,
   input wire logic [PIN_COUNT-1:0] pin_in,
   input wire logic [PIN_COUNT-1:0] pin_out,
   input wire logic [PIN_COUNT-1:0] pin_oe_out,
   input wire logic [PIN_COUNT-1:0] pin_level_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in || !ce_in);
   a_bus_answer: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered in one cycle");
   a_wait_single: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("waitrequest low too long");
   a_read_upper: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:16] == 16'h0)
      else $error("upper read bits not zero");
   a_oe_exists: assert property ((pin_oe_out & ~PIN_EXIST_MASK) == 32'h0)
      else $error("enable on missing pin");
   a_out_released: assert property ((pin_out & ~pin_oe_out) == 32'h0)
      else $error("released pin driven");
   a_out_level: assert property (pin_out == ($past(pin_drive_in) & pin_oe_out))
      else $error("driven level wrong");
   a_oe_by_write: assert property (
      !$stable(pin_oe_out) |-> $past(avs_write_in && !avs_waitrequest_out, 2))
      else $error("enable changed without write");
   a_level_track: assert property (
      $stable(pin_in)[*7] |-> pin_level_out == (pin_in & PIN_EXIST_MASK))
      else $error("level does not follow pin");
   c_write: cover property (avs_write_in && !avs_waitrequest_out);
   c_read: cover property (avs_read_in && !avs_waitrequest_out);
   c_drive: cover property (pin_out != 32'h0);
endmodule
bind gid_top gid_monitor i_mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .pin_in(pin_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .pin_drive_in(pin_drive_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
   .pin_level_out(pin_level_out));

// ---- bench/tb_top.sv ----
// self-checking bench for the pin input and direction block
// assumes every bus request is answered; ce_in stays high except during the frozen-pin check
`timescale 1ns/1ps
module tb_top;
   import gid_pkg::*;
   logic core_clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic ce_in = 1'h1;
   logic avs_read_in = 1'h0;
   logic avs_write_in = 1'h0;
   logic [17:0] avs_address_in = 18'h0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic [31:0] pin_drive_in = 32'h0;
   logic [31:0] pin_in = 32'h0;
   logic [31:0] rdata, pout, poe, plev;
   logic wreq;
   logic [31:0] exp_q[$];
   logic [15:0] dlo = 16'h0;
   logic [15:0] dhi = 16'h0;
   logic [31:0] seed = 32'h0000_8640;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   always #2.5 core_clk_in = ~core_clk_in;
   gid_top i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .pin_drive_in(pin_drive_in), .pin_in(pin_in),
      .pin_out(pout), .pin_oe_out(poe), .pin_level_out(plev));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk_pin(input string what, input logic [31:0] got, input logic [31:0] e);
      checks_done++;
      if (got !== e) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, e);
      end
   endtask
   task automatic chk_read(input logic [31:0] got, input logic [31:0] e);
      chk_pin("read", got, e);
   endtask
   task automatic end_sim();
      // a read that never completed leaves its note behind
      fail_count += exp_q.size();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do @(posedge core_clk_in); while (wreq !== 1'h0);
      avs_write_in <= 1'h0;
      avs_read_in <= 1'h0;
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'h0, a, rnd(), 4'hF);
   endtask
   // lanes 2 and 3 carry nothing; reserved upper bits never store
   task automatic wr_dir(input logic hi, input logic [31:0] d, input logic [3:0] be);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      bus(1'h1, hi ? ADDR_DIR_HIGH : ADDR_DIR_LOW, d, be);
      if (hi) dhi = (dhi & ~m) | (d[15:0] & m & UPPER_PIN_MASK);
      else dlo = (dlo & ~m) | (d[15:0] & m);
   endtask
   task automatic pins();
      repeat (3) @(posedge core_clk_in);
      #1;
      chk_pin("oe", poe, {dhi, dlo});
      chk_pin("out", pout, pin_drive_in & {dhi, dlo});
      // back on the edge so later stimulus changes at a rising edge
      @(posedge core_clk_in);
   endtask
   always @(posedge core_clk_in) begin
      if (avs_read_in && wreq === 1'h0 && exp_q.size() > 0) begin
         chk_read(rdata, exp_q.pop_front());
      end
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end
   initial begin
      logic [31:0] r;
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'h1;
      rd(ADDR_DIR_LOW, 32'h0);
      rd(ADDR_DIR_HIGH, 32'h0);
      pins();
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         pin_drive_in <= rnd();
         pin_in <= rnd();
         wr_dir(i[0], rnd() & {16'hFFFF, i[0] ? UPPER_PIN_MASK : LOWER_PIN_MASK},
                (i < 4) ? r[3:0] : 4'hF);
         rd(i[0] ? ADDR_DIR_HIGH : ADDR_DIR_LOW, {16'h0, i[0] ? dhi : dlo});
         pins();
         repeat (4) @(posedge core_clk_in);
         rd(ADDR_INPUT_LOW, {16'h0, pin_in[15:0]});
         rd(ADDR_INPUT_HIGH, {16'h0, pin_in[31:16] & UPPER_PIN_MASK});
         chk_pin("level", plev, pin_in & PIN_EXIST_MASK);
      end
      bus(1'h1, ADDR_INPUT_HIGH, 32'h0000_FFFF, 4'hF);
      rd(ADDR_INPUT_HIGH, {16'h0, pin_in[31:16] & UPPER_PIN_MASK});
      rd(ADDR_DIR_HIGH, {16'h0, dhi});
      rd(18'h00004, 32'h0);
      pins();
      // a frozen block ignores its pins until the enable returns
      ce_in <= 1'h0;
      pin_in <= ~pin_in;
      repeat (8) @(posedge core_clk_in);
      chk_pin("frozen", plev, ~pin_in & PIN_EXIST_MASK);
      ce_in <= 1'h1;
      repeat (8) @(posedge core_clk_in);
      chk_pin("thawed", plev, pin_in & PIN_EXIST_MASK);
      // a second reset in mid-run must release every pin
      rst_n_in <= 1'h0;
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'h1;
      dlo = 16'h0;
      dhi = 16'h0;
      pins();
      rd(ADDR_DIR_LOW, 32'h0);
      repeat (2) @(posedge core_clk_in);
      end_sim();
   end
endmodule

// ---- hw/gid_pkg.sv ----
// constants shared by the pin input and direction block
// assumes one core clock and a byte-addressed register bus
package gid_pkg;

   // register data and pin counts
   localparam int WORD_W = 16;
   localparam int PIN_COUNT = 32;
   localparam int UPPER_BASE = 16;
   localparam int BUS_DATA_W = 32;
   localparam int BUS_BE_W = 4;
   localparam int BYTE_W = 8;
   localparam int BUS_ADDR_MIN_W = 18;

   // register indices; the byte address is four times the index
   localparam logic [15:0] REG_INPUT_LOW_IDX = 16'hC020;
   localparam logic [15:0] REG_DIR_LOW_IDX = 16'hC022;
   localparam logic [15:0] REG_INPUT_HIGH_IDX = 16'hC026;
   localparam logic [15:0] REG_DIR_HIGH_IDX = 16'hC028;

   // byte addresses of the registers
   localparam logic [17:0] ADDR_INPUT_LOW = {REG_INPUT_LOW_IDX, 2'b00};
   localparam logic [17:0] ADDR_DIR_LOW = {REG_DIR_LOW_IDX, 2'b00};
   localparam logic [17:0] ADDR_INPUT_HIGH = {REG_INPUT_HIGH_IDX, 2'b00};
   localparam logic [17:0] ADDR_DIR_HIGH = {REG_DIR_HIGH_IDX, 2'b00};

   // pins that exist in each word
   localparam logic [15:0] LOWER_PIN_MASK = 16'hFFFF;
   localparam logic [15:0] UPPER_PIN_MASK = 16'hE1F8;
   localparam logic [31:0] PIN_EXIST_MASK = {UPPER_PIN_MASK, LOWER_PIN_MASK};

   // reset values
   localparam logic [15:0] DIR_RESET = 16'h0000;
   localparam logic [15:0] INPUT_RESET = 16'h0000;
   localparam logic [31:0] PIN_RESET = 32'h0000_0000;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

   // bus answer states, one-hot
   typedef enum logic [1:0] {
      GID_BUS_IDLE = 2'b01,
      GID_BUS_ANSWER = 2'b10
   } gid_bus_state_e;

endpackage

// ---- hw/gid_sync.sv ----
// three-stage pin input synchroniser with agreement filter
// assumes asynchronous pin levels and one core clock
`timescale 1ns/1ps
module gid_sync
   import gid_pkg::*;
#(
   parameter int WIDTH = PIN_COUNT
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out
);

   // refused at elaboration, so a bad width never reaches simulation
   if (WIDTH < 1) begin : g_bad_width
      $error("gid_sync width must be at least one");
   end

   genvar bit_i;
   generate
      for (bit_i = 0; bit_i < WIDTH; bit_i++) begin : g_bit
         logic stage1;
         logic stage2;
         logic stage3;

         // stage1 feeds stage2 only, to keep metastability contained
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
               stage3 <= 1'b0;
            end else if (ce_in) begin
               stage1 <= async_in[bit_i];
               stage2 <= stage1;
               stage3 <= stage2;
            end
         end

         // a change counts once stage2 and stage3 agree
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               level_out[bit_i] <= 1'b0;
            end else if (ce_in && (stage2 == stage3)) begin
               level_out[bit_i] <= stage3;
            end
         end
      end
   endgenerate

endmodule

// ---- hw/gid_top.sv ----
// pin input sampling and direction control with an avalon-mm slave
// assumes the output data path feeds pin_drive_in on the same clock
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module gid_top
   import gid_pkg::*;
#(
   parameter int ADDR_W = BUS_ADDR_MIN_W
) (
   // clock, reset and enable
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [BUS_DATA_W-1:0] avs_writedata_in,
   input wire logic [BUS_BE_W-1:0] avs_byteenable_in,
   output logic [BUS_DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // output data path of the port
   input wire logic [PIN_COUNT-1:0] pin_drive_in,
   // pins
   input wire logic [PIN_COUNT-1:0] pin_in,
   output logic [PIN_COUNT-1:0] pin_out,
   output logic [PIN_COUNT-1:0] pin_oe_out,
   // sampled levels for the rest of the port
   output logic [PIN_COUNT-1:0] pin_level_out
);

   // refused at elaboration, so a narrow bus never reaches simulation
   if (ADDR_W < BUS_ADDR_MIN_W) begin : g_bad_addr_w
      $error("gid_top address width too narrow for the register map");
   end

   gid_bus_state_e bus_state;
   gid_bus_state_e next_bus_state;
   logic [WORD_W-1:0] pin_direction_low;
   logic [WORD_W-1:0] pin_direction_high;
   logic [PIN_COUNT-1:0] level;
   logic [WORD_W-1:0] pin_input_low;
   logic [WORD_W-1:0] pin_input_high;
   logic bus_req;
   logic hit_input_low;
   logic hit_input_high;
   logic hit_dir_low;
   logic hit_dir_high;
   logic commit_write;
   logic [WORD_W-1:0] lane_mask;
   logic [WORD_W-1:0] wr_word;
   logic [WORD_W-1:0] read_word;
   logic [PIN_COUNT-1:0] dir_all;

   // pin synchroniser, three stages with agreement filter
   gid_sync #(
      .WIDTH(PIN_COUNT)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .async_in(pin_in),
      .level_out(level)
   );

   // pin level view
   // the words look at the pin itself, so an output pin reads back its real level
   // word bit mapping
   assign pin_input_low = level[WORD_W-1:0] & LOWER_PIN_MASK;
   assign pin_input_high = level[PIN_COUNT-1:UPPER_BASE] & UPPER_PIN_MASK;

   // address decode on aligned byte addresses
   assign bus_req = avs_read_in | avs_write_in;
   assign hit_input_low = (avs_address_in == ADDR_W'(ADDR_INPUT_LOW));
   assign hit_input_high = (avs_address_in == ADDR_W'(ADDR_INPUT_HIGH));
   assign hit_dir_low = (avs_address_in == ADDR_W'(ADDR_DIR_LOW));
   assign hit_dir_high = (avs_address_in == ADDR_W'(ADDR_DIR_HIGH));

   // byte lanes 0 and 1 carry the 16-bit word
   assign lane_mask = {{BYTE_W{avs_byteenable_in[1]}}, {BYTE_W{avs_byteenable_in[0]}}};
   assign wr_word = avs_writedata_in[WORD_W-1:0];

   // a write lands at the edge where the master sees waitrequest low
   assign commit_write = ce_in && (bus_state == GID_BUS_ANSWER) && avs_write_in;

   // read mux; unmapped addresses read zero
   always_comb begin
      read_word = INPUT_RESET;
      if (hit_input_low) begin
         read_word = pin_input_low;
      end else if (hit_input_high) begin
         read_word = pin_input_high;
      end else if (hit_dir_low) begin
         read_word = pin_direction_low;
      end else if (hit_dir_high) begin
         read_word = pin_direction_high;
      end
   end

   // bus answer sequence: one wait cycle, then one answer cycle
   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         GID_BUS_IDLE: begin
            if (bus_req) begin
               next_bus_state = GID_BUS_ANSWER;
            end
         end
         GID_BUS_ANSWER: begin
            next_bus_state = GID_BUS_IDLE;
         end
         default: begin
            next_bus_state = GID_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_state <= GID_BUS_IDLE;
      end else if (ce_in) begin
         bus_state <= next_bus_state;
      end
   end

   // waitrequest idles high so no request completes before it is decoded
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_waitrequest_out <= 1'b1;
      end else if (ce_in) begin
         avs_waitrequest_out <= !((bus_state == GID_BUS_IDLE) && bus_req);
      end
   end

   // read data is captured as waitrequest drops and holds until the next read
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= BUS_ZERO;
      end else if (ce_in && (bus_state == GID_BUS_IDLE) && avs_read_in) begin
         avs_readdata_out <= {{(BUS_DATA_W - WORD_W){1'b0}}, read_word};
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_direction_low <= DIR_RESET;
      end else if (commit_write && hit_dir_low) begin
         pin_direction_low <= ((pin_direction_low & ~lane_mask) | (wr_word & lane_mask))
                              & LOWER_PIN_MASK;
      end
   end

   // upper direction store
   // reserved positions are masked so a careless write cannot drive a missing pin
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_direction_high <= DIR_RESET;
      end else if (commit_write && hit_dir_high) begin
         pin_direction_high <= ((pin_direction_high & ~lane_mask) | (wr_word & lane_mask))
                               & UPPER_PIN_MASK;
      end
   end

   // input words not writable
   // no store exists behind the input words, so a write there only completes

   assign dir_all = {pin_direction_high, pin_direction_low};

   genvar pin_i;
   generate
      for (pin_i = 0; pin_i < PIN_COUNT; pin_i++) begin : g_pin
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               pin_oe_out[pin_i] <= 1'b0;
            end else if (ce_in) begin
               pin_oe_out[pin_i] <= dir_all[pin_i] & PIN_EXIST_MASK[pin_i];
            end
         end

         // data level drive
         // low while released so the pad never sees stale data at turn-on
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               pin_out[pin_i] <= 1'b0;
            end else if (ce_in) begin
               pin_out[pin_i] <= pin_drive_in[pin_i] & dir_all[pin_i] & PIN_EXIST_MASK[pin_i];
            end
         end
      end
   endgenerate

   // sampled levels for interrupt and mux logic elsewhere in the port
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_level_out <= PIN_RESET;
      end else if (ce_in) begin
         pin_level_out <= level & PIN_EXIST_MASK;
      end
   end

endmodule
